// [logic/acsr_pkg.sv]
// acsr_pkg: constants, pin layout and state codes of the converter
// control and serial readout block.
// assumes: 50 MHz system clock and a 16-bit code from the SAR core.
package acsr_pkg;

  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int T_CLK_NS   = 20;   // system clock period
  localparam int RC_MIN_NS  = 50;   // least low time of the request
  localparam int RC_MIN_CYC = (RC_MIN_NS + T_CLK_NS - 1) / T_CLK_NS;
  localparam int CONV_NS    = 4000; // conversion time
  localparam int CONV_CYC   = CONV_NS / T_CLK_NS;
  localparam int ISCLK_HALF = 4;    // cycles per internal clock phase

  // --------------------------------------------------------------
  // widths and counter end values
  // --------------------------------------------------------------
  localparam int WORD_W = 16;       // result width
  localparam int LCNT_W = 2;        // low-time counter
  localparam int CCNT_W = 8;        // conversion counter
  localparam int IPC_W  = 3;        // internal clock phase counter
  localparam int CNT_W  = 5;        // link edge and bit counters
  localparam logic [LCNT_W-1:0] LCNT_MAX = LCNT_W'(RC_MIN_CYC - 1);
  localparam logic [CCNT_W-1:0] CCNT_END = CCNT_W'(CONV_CYC - 1);
  localparam logic [IPC_W-1:0]  IPC_HI   = IPC_W'(ISCLK_HALF);
  localparam logic [IPC_W-1:0]  IPC_END  = IPC_W'(2 * ISCLK_HALF - 1);
  localparam logic [CNT_W-1:0]  BIT_CNT  = CNT_W'(WORD_W);
  localparam logic [CNT_W-1:0]  TAG_IDX  = CNT_W'(WORD_W + 1);
  localparam logic [CNT_W-1:0]  CNT_SAT  = 5'h1F;
  localparam logic [3:0]        MSB_IDX  = 4'(WORD_W - 1);

  // --------------------------------------------------------------
  // pin vector layout and reset values
  // --------------------------------------------------------------
  localparam int P_RC   = 0;        // read/convert
  localparam int P_CS   = 1;        // chip select, low active
  localparam int P_EXT  = 2;        // clock source select
  localparam int P_PD   = 3;        // power down
  localparam int P_TAG  = 4;        // daisy-chain input
  localparam int PIN_W  = 5;
  localparam logic [PIN_W-1:0]  PIN_RST = 5'h03;
  localparam logic [WORD_W-1:0] RES_RST = 16'h0000;

  // conversion state, one-hot
  typedef enum logic [1:0] {
    CV_TRACK = 2'b01,
    CV_CONV  = 2'b10
  } acsr_state_e;

endpackage : acsr_pkg

// [logic/acsr_link_if.sv]
// acsr_link_if: bundle between the system-clock control and the
// readout running on the host data clock.
// assumes: word only changes at the end of a conversion.
`timescale 1ns/1ps
interface acsr_link_if;
  logic [15:0] word;    // result offered for readout
  logic        frst;    // frame idle, async reset of the readout
  logic        aclr;    // clears the marker arming
  logic        tag_raw; // daisy-chain pin, not synchronised
  logic        data;    // serial bit from the readout
  logic        sync;    // frame marker from the readout
  modport ctl (output word, frst, aclr, tag_raw, input data, sync);
  modport rd  (input word, frst, aclr, tag_raw, output data, sync);
endinterface : acsr_link_if

// [logic/acsr_link_rd.sv]
// acsr_link_rd: serial readout on the host-supplied data clock.
// assumes: frst and aclr come from system-clock registers; word is
// steady while a frame samples it.
`timescale 1ns/1ps
module acsr_link_rd
  import acsr_pkg::*;
(
  // host data clock
  input wire logic lclk_i,
  // bundle to the control side
  acsr_link_if.rd  lnk
);

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  logic              tg_m;      // tag first stage
  logic              tg_s;      // tag second stage
  logic              arm_reg;   // an edge came while idle
  logic [CNT_W-1:0]  cnt_reg;   // rising edges in this frame
  logic [CNT_W-1:0]  cnt_next;
  logic              sm_reg;    // this frame carries a marker
  logic              sm_next;
  logic              tcap_reg;  // tag taken at the first data edge
  logic              tcap_next;
  logic [WORD_W-1:0] snap_reg;  // result frozen for the frame
  logic [WORD_W-1:0] snap_next;
  logic              dat_reg;   // serial data out
  logic              dat_next;
  logic              syn_reg;   // marker out
  logic              syn_next;
  logic [CNT_W-1:0]  idx;       // slot number after this edge

  // tag synchroniser, free running on the data clock
  always_ff @(posedge lclk_i)
  begin
    tg_m <= lnk.tag_raw;
    tg_s <= tg_m;
  end

  // any edge arms the marker; cleared when a frame closes
  always_ff @(posedge lclk_i or posedge lnk.aclr)
  begin
    if (lnk.aclr)
      arm_reg <= 1'b0;
    else
      arm_reg <= 1'b1;
  end

  // next slot: marker, 16 data bits, then the tag level
  always_comb
  begin
    cnt_next  = (cnt_reg == CNT_SAT) ? cnt_reg : cnt_reg + 1'b1;
    sm_next   = sm_reg;
    tcap_next = tcap_reg;
    snap_next = snap_reg;
    dat_next  = dat_reg;
    syn_next  = 1'b0;
    // first edge decides on the marker from the arming
    if (cnt_reg == '0)
      sm_next = arm_reg;
    idx = cnt_next - {4'h0, sm_next};
    if (sm_next && idx == '0)
      syn_next = 1'b1;
    else if (idx == 5'h01)
    begin
      // freeze the word and send the MSB
      snap_next = lnk.word;
      dat_next  = lnk.word[WORD_W-1];
      tcap_next = tg_s;
    end
    else if (idx > 5'h01 && idx <= BIT_CNT)
      dat_next = snap_reg[4'(BIT_CNT - idx)];
    else if (idx == TAG_IDX)
      dat_next = tcap_reg;
  end

  // frame registers, held idle while the read is closed
  always_ff @(posedge lclk_i or posedge lnk.frst)
  begin
    if (lnk.frst)
    begin
      cnt_reg  <= '0;
      sm_reg   <= 1'b0;
      tcap_reg <= 1'b0;
      snap_reg <= RES_RST;
      dat_reg  <= 1'b0;
      syn_reg  <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      sm_reg   <= sm_next;
      tcap_reg <= tcap_next;
      snap_reg <= snap_next;
      dat_reg  <= dat_next;
      syn_reg  <= syn_next;
    end
  end

  assign lnk.data = dat_reg;
  assign lnk.sync = syn_reg;

  // --------------------------------------------------------------
  // checks on the data clock
  // --------------------------------------------------------------
  default clocking lcb @(posedge lclk_i);
  endclocking
  default disable iff (lnk.frst);

  a_marker_single :
    assert property (syn_reg |=> !syn_reg && dat_reg == snap_reg[15])
    else $error("marker longer than one clock or MSB missing");
  a_tag_slot :
    assert property ((idx == TAG_IDX) |=> dat_reg == tcap_reg)
    else $error("tag level not on data after the LSB");
  c_marker : cover property (syn_reg);
  c_tag_out : cover property (idx == TAG_IDX && !sm_next);

endmodule : acsr_link_rd

// [logic/acsr_top.sv]
// acsr_top: conversion control, internal data clock and serial
// result output of a 16-bit successive-approximation converter.
// assumes: mclk_i at 50 MHz; the SAR core presents its code on
// sar_code_i by the end of the conversion time; the host data clock
// arrives on serial_shift_clock_i in external mode only.
`timescale 1ns/1ps
module acsr_top
  import acsr_pkg::*;
(
  // system clock and reset
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  // host data clock, external mode
  input  wire logic              serial_shift_clock_i,
  // conversion and read control pins
  input  wire logic              rd_cnv_i,
  input  wire logic              cs_n_i,
  input  wire logic              clock_source_select_i,
  input  wire logic              power_down_input_i,
  input  wire logic              tag_i,
  // code from the SAR core
  input  wire logic [WORD_W-1:0] sar_code_i,
  // status and serial pins
  output logic                   busy_n_o,
  output logic                   data_o,
  output logic                   frame_sync_o,
  output logic                   serial_shift_clock_o,
  output logic                   serial_shift_clock_oe_o
);

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  logic [PIN_W-1:0] pin_m;  // first stage, read only by pin_s
  logic [PIN_W-1:0] pin_s;  // second stage
  logic             rc_s;   // read/convert
  logic             cs_s;   // chip select, low active
  logic             ext_s;  // external clock selected
  logic             pd_s;   // power down
  logic             tag_s;  // daisy-chain input

  // two flops per pin, idle levels after reset
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      pin_m <= PIN_RST;
      pin_s <= PIN_RST;
    end
    else
    begin
      pin_m <= {tag_i, power_down_input_i, clock_source_select_i,
                cs_n_i, rd_cnv_i};
      pin_s <= pin_m;
    end
  end

  assign rc_s  = pin_s[P_RC];
  assign cs_s  = pin_s[P_CS];
  assign ext_s = pin_s[P_EXT];
  assign pd_s  = pin_s[P_PD];
  assign tag_s = pin_s[P_TAG];

  // --------------------------------------------------------------
  // conversion control
  // --------------------------------------------------------------
  acsr_state_e       st_reg;     // tracking or converting
  acsr_state_e       st_next;
  logic [LCNT_W-1:0] lcnt_reg;   // cycles the request has been low
  logic [LCNT_W-1:0] lcnt_next;
  logic              rdy_reg;    // request went high since last start
  logic              rdy_next;
  logic [CCNT_W-1:0] ccnt_reg;   // conversion time counter
  logic [CCNT_W-1:0] ccnt_next;
  logic              busy_reg;   // busy pin, low while converting
  logic              busy_next;
  logic [WORD_W-1:0] res_reg;    // last finished result
  logic [WORD_W-1:0] res_next;
  logic              tagc_reg;   // tag level at conversion start
  logic              tagc_next;
  logic              comb_low;   // both request pins low
  logic              start;      // a conversion begins

  // either pin may fall first; the pair acts as one request
  assign comb_low = ~(rc_s | cs_s);

  // start after the request has been seen low long enough
  assign start = (st_reg == CV_TRACK) & rdy_reg & comb_low
               & (lcnt_reg == LCNT_MAX) & ~pd_s;

  // next state of the conversion sequence
  always_comb
  begin
    st_next   = st_reg;
    lcnt_next = lcnt_reg;
    rdy_next  = rdy_reg;
    ccnt_next = ccnt_reg;
    res_next  = res_reg;
    tagc_next = tagc_reg;
    // count the low time, restart on any high sample
    if (!comb_low)
    begin
      lcnt_next = '0;
      rdy_next  = 1'b1;
    end
    else if (lcnt_reg != LCNT_MAX)
      lcnt_next = lcnt_reg + 1'b1;
    unique case (st_reg)
      CV_TRACK:
      begin
        // input is held and the conversion runs
        if (start)
        begin
          st_next   = CV_CONV;
          ccnt_next = '0;
          rdy_next  = 1'b0;
          tagc_next = tag_s;
        end
      end
      CV_CONV:
      begin
        ccnt_next = ccnt_reg + 1'b1;
        // end of conversion: latch the code, resume tracking
        if (ccnt_reg == CCNT_END)
        begin
          st_next  = CV_TRACK;
          res_next = sar_code_i;
        end
      end
      default:
        st_next = CV_TRACK;
    endcase
    busy_next = (st_next != CV_CONV);
  end

  // conversion registers; result starts at a fixed code
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      st_reg   <= CV_TRACK;
      lcnt_reg <= '0;
      rdy_reg  <= 1'b0;
      ccnt_reg <= '0;
      busy_reg <= 1'b1;
      res_reg  <= RES_RST;
      tagc_reg <= 1'b0;
    end
    else
    begin
      st_reg   <= st_next;
      lcnt_reg <= lcnt_next;
      rdy_reg  <= rdy_next;
      ccnt_reg <= ccnt_next;
      busy_reg <= busy_next;
      res_reg  <= res_next;
      tagc_reg <= tagc_next;
    end
  end

  // --------------------------------------------------------------
  // internal data clock and serial output
  // --------------------------------------------------------------
  logic              iact_reg;   // internal shift in progress
  logic              iact_next;
  logic [IPC_W-1:0]  ipc_reg;    // phase within one clock pulse
  logic [IPC_W-1:0]  ipc_next;
  logic [CNT_W-1:0]  ibit_reg;   // pulses already sent
  logic [CNT_W-1:0]  ibit_next;
  logic              isclk_reg;  // internal clock level
  logic              isclk_next;
  logic              idata_reg;  // internal data level
  logic              idata_next;
  logic              oe_reg;     // device drives the clock pin
  logic              oe_next;

  // divider: low half then high half; data moves one cycle
  // after the falling edge so both edges see it steady
  always_comb
  begin
    iact_next  = iact_reg;
    ipc_next   = ipc_reg;
    ibit_next  = ibit_reg;
    idata_next = idata_reg;
    oe_next    = ~ext_s;
    if (start && !ext_s)
    begin
      // previous result goes out during this conversion
      iact_next = 1'b1;
      ipc_next  = '0;
      ibit_next = '0;
    end
    else if (iact_reg)
    begin
      ipc_next = (ipc_reg == IPC_END) ? '0 : ipc_reg + 1'b1;
      if (ipc_reg == IPC_END)
        ibit_next = ibit_reg + 1'b1;
      if (ipc_reg == '0)
      begin
        if (ibit_reg == BIT_CNT)
        begin
          // after the LSB: tag level, clock parked low
          idata_next = tagc_reg;
          iact_next  = 1'b0;
        end
        else
          idata_next = res_reg[MSB_IDX - ibit_reg[3:0]];
      end
    end
    isclk_next = iact_next & (ipc_next >= IPC_HI);
  end

  // internal clock registers
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      iact_reg  <= 1'b0;
      ipc_reg   <= '0;
      ibit_reg  <= '0;
      isclk_reg <= 1'b0;
      idata_reg <= 1'b0;
      oe_reg    <= 1'b0;
    end
    else
    begin
      iact_reg  <= iact_next;
      ipc_reg   <= ipc_next;
      ibit_reg  <= ibit_next;
      isclk_reg <= isclk_next;
      idata_reg <= idata_next;
      oe_reg    <= oe_next;
    end
  end

  // --------------------------------------------------------------
  // external read framing and readout on the host clock
  // --------------------------------------------------------------
  logic open_reg;   // a read is open
  logic open_next;
  logic frst_reg;   // holds the readout idle
  logic frst_next;
  logic aclr_reg;   // clears the marker arming
  logic aclr_next;

  // select low with read high opens a read; closing disarms
  always_comb
  begin
    open_next = ext_s & ~cs_s & rc_s;
    frst_next = ~open_next;
    aclr_next = open_reg & ~open_next;
  end

  // framing registers, readout held and disarmed in reset
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      open_reg <= 1'b0;
      frst_reg <= 1'b1;
      aclr_reg <= 1'b1;
    end
    else
    begin
      open_reg <= open_next;
      frst_reg <= frst_next;
      aclr_reg <= aclr_next;
    end
  end

  // readout on the host clock; word changes only at conversion end
  acsr_link_if lnk ();
  assign lnk.word    = res_reg;
  assign lnk.frst    = frst_reg;
  assign lnk.aclr    = aclr_reg;
  assign lnk.tag_raw = tag_i;

  acsr_link_rd u_rd (
    .lclk_i (serial_shift_clock_i),
    .lnk    (lnk)
  );

  // --------------------------------------------------------------
  // pin drivers
  // --------------------------------------------------------------
  assign busy_n_o                = busy_reg;
  assign serial_shift_clock_o    = isclk_reg;
  assign serial_shift_clock_oe_o = oe_reg;
  assign data_o                  = oe_reg ? idata_reg : lnk.data;
  assign frame_sync_o            = lnk.sync;

  // --------------------------------------------------------------
  // checks on the system clock
  // --------------------------------------------------------------
  logic [CNT_W-1:0] pls_reg;  // internal clock pulses this conversion

  // count rising internal clock edges since the last start
  always_ff @(posedge mclk_i)
  begin
    if (reset_i || start)
      pls_reg <= '0;
    else if (isclk_next && !isclk_reg)
      pls_reg <= pls_reg + 1'b1;
  end

  default clocking mcb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  a_start_busy :
    assert property (start |=> !busy_reg && st_reg == CV_CONV)
    else $error("busy not low after a start");
  a_busy_hold :
    assert property ((!busy_reg && ccnt_reg != CCNT_END) |=> !busy_reg)
    else $error("busy released before the conversion ended");
  a_busy_release :
    assert property ((st_reg == CV_CONV && ccnt_reg == CCNT_END)
      |=> busy_reg && res_reg == $past(sar_code_i))
    else $error("busy or result wrong at conversion end");
  a_low_time :
    assert property (start |-> $past(comb_low, 1) && $past(comb_low, 2))
    else $error("conversion started on a short request");
  a_pd_hold :
    assert property ((pd_s && st_reg == CV_TRACK)
      |=> st_reg == CV_TRACK && $stable(res_reg))
    else $error("conversion or result change in power down");
  a_pulse_count :
    assert property ($fell(iact_reg) |-> pls_reg == BIT_CNT)
    else $error("internal clock did not give 16 pulses");
  a_bit_stable :
    assert property (isclk_reg |-> $stable(idata_reg) ##1
                     $stable(idata_reg))
    else $error("data moved around an internal clock edge");
  a_tag_park :
    assert property ($fell(iact_reg)
      |-> idata_reg == tagc_reg && !isclk_reg && !busy_reg)
    else $error("tag or parked clock wrong after the LSB");
  c_int_done : cover property ($fell(iact_reg));
  c_ext_start : cover property (start && ext_s);

endmodule : acsr_top

// [testbench/acsr_host_model.sv]
// acsr_host_model: host controller partner of the converter block.
// assumes: its tasks are called from the bench; the data clock it
// makes idles low and runs inside read frames and in lone pulse() calls.
`timescale 1ns/1ps
module acsr_host_model
  import acsr_pkg::*;
(
  // pacing clock
  input  wire logic mclk_i,
  // serial pins from the device
  input  wire logic data_i,
  input  wire logic sync_i,
  // pins driven by the host
  output logic      rd_cnv_o,
  output logic      cs_n_o,
  output logic      lclk_o
);
  // idle: no request, clock low
  initial
  begin
    rd_cnv_o = 1'b1;
    cs_n_o   = 1'b1;
    lclk_o   = 1'b0;
  end

  // start a conversion; rc_first picks which pin falls first
  task automatic convert(input logic rc_first);
    @(negedge mclk_i);
    rd_cnv_o = 1'b1;
    cs_n_o   = 1'b1;
    @(negedge mclk_i);
    rd_cnv_o = !rc_first;
    cs_n_o   = rc_first;
    @(negedge mclk_i); // falls 20 ns apart
    rd_cnv_o = 1'b0;
    cs_n_o   = 1'b0;
    repeat (4) @(negedge mclk_i); // request low 80 ns
    rd_cnv_o = 1'b1;
  endtask : convert

  // move chip select at a falling system edge
  task automatic set_cs(input logic v);
    @(negedge mclk_i);
    cs_n_o = v;
  endtask : set_cs

  // one data clock pulse, 66 ns period: the fastest the host may run
  task automatic pulse;
    #33 lclk_o = 1'b1;
    #33 lclk_o = 1'b0;
  endtask : pulse

  // discontinuous read of n pulses, latching on falling edges
  task automatic read(input int n, output logic [17:0] bits,
                      output logic [17:0] syncs);
    bits  = '0;
    syncs = '0;
    repeat (5) @(negedge mclk_i); // let the read open first
    #7;
    for (int i = 0; i < n; i++) // 16 or more pulses
    begin
      pulse();
      bits[i]  = data_i;
      syncs[i] = sync_i;
    end
  endtask : read
endmodule : acsr_host_model

// [testbench/tb.sv]
// tb: self-checking bench of the converter control and readout.
// assumes: acsr_host_model plays the host; clock pin level is the
// driven one of device and host.
`timescale 1ns/1ps
module tb;
  import acsr_pkg::*;
  logic        mclk, reset, ext_sel, pd, tag; // bench-driven pins
  logic [15:0] code;                         // SAR core code
  logic [17:0] bits, syncs;                  // captured frame
  wire logic   busy_n, data, fsync, sclk_o, sclk_oe;
  wire logic   rd_cnv, cs_n, lclk, sclk_w;
  int          n_fail = 0;
  int          check_count = 0;
  // clock pin wire: device drives it in internal mode
  assign sclk_w = sclk_oe ? sclk_o : lclk;

  acsr_top acsr_top_inst (.mclk_i(mclk), .reset_i(reset),
    .serial_shift_clock_i(sclk_w), .rd_cnv_i(rd_cnv), .cs_n_i(cs_n),
    .clock_source_select_i(ext_sel), .power_down_input_i(pd),
    .tag_i(tag), .sar_code_i(code), .busy_n_o(busy_n), .data_o(data),
    .frame_sync_o(fsync), .serial_shift_clock_o(sclk_o),
    .serial_shift_clock_oe_o(sclk_oe));
  acsr_host_model acsr_host_model_inst (.mclk_i(mclk), .data_i(data),
    .sync_i(fsync), .rd_cnv_o(rd_cnv), .cs_n_o(cs_n), .lclk_o(lclk));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // wait, bounded, for busy to reach a level
  task automatic wait_busy(input logic lvl);
    int k;
    k = 0;
    while (busy_n !== lvl && k < 400)
    begin
      @(negedge mclk);
      k++;
    end
    check(16'(busy_n), 16'(lvl));
  endtask : wait_busy

  // frame bits from offset off must be word w, msb first
  task automatic chk_word(input int off, input logic [15:0] w);
    for (int i = 0; i < 16; i++)
      check(16'(bits[i+off]), 16'(w[15-i]));
  endtask : chk_word

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_internal;
    int k;
    logic d;
    @(negedge mclk);
    code = 16'hA5C3;
    acsr_host_model_inst.convert(1'b1);
    wait_busy(1'b0);
    k = 0;
    while (busy_n === 1'b0 && k < 400)
    begin
      @(negedge mclk);
      k++;
    end
    check(16'(k), 16'(CONV_CYC));
    code = 16'h3C5A;
    acsr_host_model_inst.convert(1'b0);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge sclk_o);
      #1 d = data;
      check(16'(sclk_oe), 16'h0001);
      @(negedge sclk_o);
      check(16'(data), 16'(d));
      check(16'(d), 16'(16'hA5C3 >> (15 - i)) & 16'h0001);
    end
    repeat (2) @(negedge mclk);
    check(16'(data), 16'(tag));
    check(16'(busy_n), 16'h0000);
    wait_busy(1'b1);
    check(16'(sclk_o), 16'h0000);
    $display("test internal done");
  endtask : t_internal

  task automatic t_ext_after;
    @(negedge mclk);
    ext_sel = 1'b1;
    tag     = 1'b1;
    code    = 16'h8001;
    acsr_host_model_inst.convert(1'b0);
    wait_busy(1'b0);
    wait_busy(1'b1);
    acsr_host_model_inst.read(17, bits, syncs);
    chk_word(0, 16'h8001);
    check(syncs[15:0], 16'h0000);
    check(16'(sclk_oe), 16'h0000);
    $display("test external after done");
  endtask : t_ext_after

  task automatic t_ext_during;
    @(negedge mclk);
    code = 16'h7FFE;
    acsr_host_model_inst.convert(1'b1);
    wait_busy(1'b0);
    acsr_host_model_inst.read(17, bits, syncs);
    check(16'(busy_n), 16'h0000);
    chk_word(0, 16'h8001);
    check(16'(bits[16]), 16'(tag));
    check(syncs[15:0], 16'h0000);
    wait_busy(1'b1);
    $display("test external during done");
  endtask : t_ext_during

  task automatic t_marker;
    tag = 1'b0; // other daisy-chain level, settled before the arming edge
    acsr_host_model_inst.set_cs(1'b1);
    repeat (3) @(negedge mclk);
    acsr_host_model_inst.pulse(); // edge while read closed
    repeat (3) @(negedge mclk);
    acsr_host_model_inst.set_cs(1'b0); // read opens
    acsr_host_model_inst.read(18, bits, syncs);
    check(16'(syncs[0]), 16'h0001);
    check(16'(syncs[1]), 16'h0000);
    chk_word(1, 16'h7FFE);
    check(16'(bits[17]), 16'(tag));
    $display("test marker done");
  endtask : t_marker

  task automatic t_power_down;
    @(negedge mclk);
    pd   = 1'b1;
    code = 16'h1234;
    acsr_host_model_inst.convert(1'b0);
    repeat (40) @(negedge mclk);
    check(16'(busy_n), 16'h0001);
    // outlast a whole conversion so a wrongful start would load 1234
    repeat (170) @(negedge mclk);
    pd = 1'b0;
    acsr_host_model_inst.read(16, bits, syncs);
    chk_word(0, 16'h7FFE);
    $display("test power down done");
  endtask : t_power_down

  // system clock, 20 ns
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // watchdog against a hang
  initial
  begin
    #200000;
    n_fail++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    give_verdict();
  end

  // main sequence
  initial
  begin
    reset   = 1'b1;
    ext_sel = 1'b0;
    pd      = 1'b0;
    tag     = 1'b0;
    code    = 16'h0000;
    repeat (4) @(negedge mclk);
    reset = 1'b0;
    check(16'(busy_n), 16'h0001);
    check(16'(sclk_oe), 16'h0000);
    t_internal();
    t_ext_after();
    t_ext_during();
    t_marker();
    t_power_down();
    give_verdict();
  end
endmodule : tb
